// ### include/aie_consts.vh
// constants for the add instruction execution unit
`ifndef AIE_CONSTS_VH
`define AIE_CONSTS_VH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define AIE_OP_ADD_B_TO_A 8'h1B
`define AIE_OP_ADD_B_TO_IDX 8'h3A
`define AIE_OP_PAGE_Y 8'h18
`define AIE_OP_ADC_A_LIT 8'h89
`define AIE_OP_ADC_A_DIR 8'h99
`define AIE_OP_ADC_A_FULL 8'hB9
`define AIE_OP_ADC_A_XOFF 8'hA9
`define AIE_OP_ADC_B_LIT 8'hC9
`define AIE_OP_ADC_B_DIR 8'hD9
`define AIE_OP_ADC_B_FULL 8'hF9
`define AIE_OP_ADC_B_XOFF 8'hE9

// ----------------------------------------
// opcode fields of the add-with-carry group
// ----------------------------------------
`define AIE_ACC_SEL_BIT 6
`define AIE_MODE_HI 5
`define AIE_MODE_LO 4
`define AIE_MODE_LIT 2'h0
`define AIE_MODE_DIR 2'h1
`define AIE_MODE_OFF 2'h2
`define AIE_MODE_FULL 2'h3

// ----------------------------------------
// addresses
// ----------------------------------------
`define AIE_IDLE_ADDR 16'hFFFF
`define AIE_PAGE0_HI 8'h00
`define AIE_RESET_PC 16'h0000

// ----------------------------------------
// condition flag bit positions and reset value
// ----------------------------------------
`define AIE_CC_H 5
`define AIE_CC_N 3
`define AIE_CC_Z 2
`define AIE_CC_V 1
`define AIE_CC_C 0
`define AIE_CC_RESET 8'hD0

// ----------------------------------------
// load port selectors
// ----------------------------------------
`define AIE_LD_A 3'h0
`define AIE_LD_B 3'h1
`define AIE_LD_X 3'h2
`define AIE_LD_Y 3'h3
`define AIE_LD_CC 3'h4
`define AIE_LD_PC 3'h5

`endif

// ### logic/aie_add_exec.v
// execution and bus sequencing for the add instruction group
`timescale 1ns/1ps
`include "aie_consts.vh"

module aie_add_exec
#(
   parameter [15:0] RESET_PC = `AIE_RESET_PC
)
(
   input wire core_clk,
   input wire arst_n,
   input wire run,
   input wire load_en,
   input wire [2:0] load_sel,
   input wire [15:0] load_data,
   output reg [15:0] bus_addr,
   output wire bus_rw,
   output wire bus_cycle,
   input wire [7:0] bus_rdata,
   output reg [7:0] accumulator_a,
   output reg [7:0] accumulator_b,
   output reg [15:0] index_x,
   output reg [15:0] index_y,
   output reg [7:0] condition_flags,
   output reg [15:0] pc,
   output reg [15:0] rel_target,
   output reg instr_done,
   output reg bad_opcode
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [2:0] ST_FETCH = 3'h0;
   localparam [2:0] ST_PAGE2 = 3'h1;
   localparam [2:0] ST_IGN = 3'h2;
   localparam [2:0] ST_IDLE = 3'h3;
   localparam [2:0] ST_OPND1 = 3'h4;
   localparam [2:0] ST_OPND2 = 3'h5;
   localparam [2:0] ST_MEMRD = 3'h6;

   reg [2:0] state;
   reg [7:0] opc;
   reg use_y;
   reg [15:0] ea;
   reg [7:0] add_a;
   reg [7:0] add_m;
   reg add_cin;
   wire [7:0] sum;
   wire f_h;
   wire f_n;
   wire f_z;
   wire f_v;
   wire f_c;
   wire [1:0] mode;
   wire acc_b_sel;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function is_adc;
      input [7:0] op;
      begin
         is_adc = (op == `AIE_OP_ADC_A_LIT) || (op == `AIE_OP_ADC_A_DIR) ||
                  (op == `AIE_OP_ADC_A_FULL) || (op == `AIE_OP_ADC_A_XOFF) ||
                  (op == `AIE_OP_ADC_B_LIT) || (op == `AIE_OP_ADC_B_DIR) ||
                  (op == `AIE_OP_ADC_B_FULL) || (op == `AIE_OP_ADC_B_XOFF);
      end
   endfunction

   function is_xoff;
      input [7:0] op;
      begin
         is_xoff = (op == `AIE_OP_ADC_A_XOFF) || (op == `AIE_OP_ADC_B_XOFF);
      end
   endfunction

   // every listed cycle is a read; the unit never writes
   assign bus_rw = 1'b1;
   // a fetch only starts when run is high; later cycles always run
   assign bus_cycle = (state != ST_FETCH) | run;

   assign mode = opc[`AIE_MODE_HI:`AIE_MODE_LO];
   assign acc_b_sel = opc[`AIE_ACC_SEL_BIT];

   // ----------------------------------------
   // bus address
   // ----------------------------------------
   always @*
   begin
      case (state)
         ST_IDLE: bus_addr = `AIE_IDLE_ADDR;
         ST_MEMRD: bus_addr = ea;
         default: bus_addr = pc;
      endcase
   end

   // ----------------------------------------
   // adder operand selection
   // ----------------------------------------
   always @*
   begin
      if (opc == `AIE_OP_ADD_B_TO_A)
      begin
         add_a = accumulator_a;
         add_m = accumulator_b;
         add_cin = 1'b0;
      end
      else
      begin
         add_a = acc_b_sel ? accumulator_b : accumulator_a;
         add_m = bus_rdata;
         add_cin = condition_flags[`AIE_CC_C];
      end
   end

   aie_adder u_adder
   (
      .opa(add_a),
      .opm(add_m),
      .cin(add_cin),
      .sum(sum),
      .half(f_h),
      .neg(f_n),
      .zero(f_z),
      .ovf(f_v),
      .carry(f_c)
   );

   // ----------------------------------------
   // sequencer and register file
   // ----------------------------------------
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= ST_FETCH;
         opc <= 8'h00;
         use_y <= 1'b0;
         ea <= 16'h0000;
         pc <= RESET_PC;
         accumulator_a <= 8'h00;
         accumulator_b <= 8'h00;
         index_x <= 16'h0000;
         index_y <= 16'h0000;
         condition_flags <= `AIE_CC_RESET;
         rel_target <= 16'h0000;
         instr_done <= 1'b0;
         bad_opcode <= 1'b0;
      end
      else
      begin
         instr_done <= 1'b0;
         bad_opcode <= 1'b0;
         case (state)
            ST_FETCH:
            begin
               if (run)
               begin
                  opc <= bus_rdata;
                  pc <= pc + 16'h0001;
                  use_y <= 1'b0;
                  if (bus_rdata == `AIE_OP_PAGE_Y)
                  begin
                     use_y <= 1'b1;
                     state <= ST_PAGE2;
                  end
                  else if (bus_rdata == `AIE_OP_ADD_B_TO_A || bus_rdata == `AIE_OP_ADD_B_TO_IDX)
                     state <= ST_IGN;
                  else if (is_adc(bus_rdata))
                     state <= ST_OPND1;
                  else
                  begin
                     // foreign opcodes are skipped in one cycle
                     bad_opcode <= 1'b1;
                     instr_done <= 1'b1;
                  end
               end
               else if (load_en)
               begin
                  case (load_sel)
                     `AIE_LD_A: accumulator_a <= load_data[7:0];
                     `AIE_LD_B: accumulator_b <= load_data[7:0];
                     `AIE_LD_X: index_x <= load_data;
                     `AIE_LD_Y: index_y <= load_data;
                     `AIE_LD_CC: condition_flags <= load_data[7:0];
                     `AIE_LD_PC: pc <= load_data;
                     default: pc <= pc;
                  endcase
               end
            end
            ST_PAGE2:
            begin
               opc <= bus_rdata;
               pc <= pc + 16'h0001;
               if (bus_rdata == `AIE_OP_ADD_B_TO_IDX)
                  state <= ST_IGN;
               else if (is_xoff(bus_rdata))
                  state <= ST_OPND1;
               else
               begin
                  bad_opcode <= 1'b1;
                  instr_done <= 1'b1;
                  state <= ST_FETCH;
               end
            end
            ST_IGN:
            begin
               // next byte read and dropped; pc does not move
               if (opc == `AIE_OP_ADD_B_TO_A)
               begin
                  accumulator_a <= sum;
                  condition_flags[`AIE_CC_H] <= f_h;
                  condition_flags[`AIE_CC_N] <= f_n;
                  condition_flags[`AIE_CC_Z] <= f_z;
                  condition_flags[`AIE_CC_V] <= f_v;
                  condition_flags[`AIE_CC_C] <= f_c;
                  instr_done <= 1'b1;
                  state <= ST_FETCH;
               end
               else
                  state <= ST_IDLE;
            end
            ST_IDLE:
            begin
               if (opc == `AIE_OP_ADD_B_TO_IDX)
               begin
                  if (use_y)
                     index_y <= index_y + {8'h00, accumulator_b};
                  else
                     index_x <= index_x + {8'h00, accumulator_b};
                  instr_done <= 1'b1;
                  state <= ST_FETCH;
               end
               else
                  state <= ST_MEMRD;
            end
            ST_OPND1:
            begin
               pc <= pc + 16'h0001;
               // branch target kept for later units
               rel_target <= pc + 16'h0001 + {{8{bus_rdata[7]}}, bus_rdata};
               case (mode)
                  `AIE_MODE_LIT:
                  begin
                     if (acc_b_sel)
                        accumulator_b <= sum;
                     else
                        accumulator_a <= sum;
                     condition_flags[`AIE_CC_H] <= f_h;
                     condition_flags[`AIE_CC_N] <= f_n;
                     condition_flags[`AIE_CC_Z] <= f_z;
                     condition_flags[`AIE_CC_V] <= f_v;
                     condition_flags[`AIE_CC_C] <= f_c;
                     instr_done <= 1'b1;
                     state <= ST_FETCH;
                  end
                  `AIE_MODE_DIR:
                  begin
                     ea <= {`AIE_PAGE0_HI, bus_rdata};
                     state <= ST_MEMRD;
                  end
                  `AIE_MODE_FULL:
                  begin
                     ea[15:8] <= bus_rdata;
                     state <= ST_OPND2;
                  end
                  default:
                  begin
                     ea <= (use_y ? index_y : index_x) + {8'h00, bus_rdata};
                     state <= ST_IDLE;
                  end
               endcase
            end
            ST_OPND2:
            begin
               pc <= pc + 16'h0001;
               ea[7:0] <= bus_rdata;
               state <= ST_MEMRD;
            end
            ST_MEMRD:
            begin
               if (acc_b_sel)
                  accumulator_b <= sum;
               else
                  accumulator_a <= sum;
               condition_flags[`AIE_CC_H] <= f_h;
               condition_flags[`AIE_CC_N] <= f_n;
               condition_flags[`AIE_CC_Z] <= f_z;
               condition_flags[`AIE_CC_V] <= f_v;
               condition_flags[`AIE_CC_C] <= f_c;
               instr_done <= 1'b1;
               state <= ST_FETCH;
            end
            default:
               state <= ST_FETCH;
         endcase
      end
   end

endmodule

// ### logic/aie_adder.v
// 8-bit adder with condition flag outputs
`timescale 1ns/1ps
`include "aie_consts.vh"

module aie_adder
(
   input wire [7:0] opa,
   input wire [7:0] opm,
   input wire cin,
   output wire [7:0] sum,
   output wire half,
   output wire neg,
   output wire zero,
   output wire ovf,
   output wire carry
);

   wire [8:0] full;

   assign full = {1'b0, opa} + {1'b0, opm} + {8'h00, cin};
   assign sum = full[7:0];
   // ----------------------------------------
   // flag formulas
   // ----------------------------------------
   assign half = (opa[3] & opm[3]) | (opm[3] & ~sum[3]) | (~sum[3] & opa[3]);
   assign neg = sum[7];
   assign zero = (sum == 8'h00);
   assign ovf = (opa[7] & opm[7] & ~sum[7]) | (~opa[7] & ~opm[7] & sum[7]);
   assign carry = (opa[7] & opm[7]) | (opm[7] & ~sum[7]) | (~sum[7] & opa[7]);

endmodule

// ### tb/add_instr_exec_unit_bench.sv
// self-checking bench for the add execution unit
`timescale 1ns/1ps
module add_instr_exec_unit_bench;
   typedef struct packed {logic [7:0] a, b, f; logic [15:0] x, y, rel, pc; logic relc, bad;} aie_note_t;
   logic core_clk, arst_n, run, load_en, bus_rw, bus_cycle, instr_done, bad_opcode;
   logic [2:0] load_sel;
   logic [15:0] load_data, bus_addr, index_x, index_y, pc, rel_target, mx, my, mrel, wp;
   logic [7:0] bus_rdata, accumulator_a, accumulator_b, condition_flags, ma, mb, mf;
   // last two are foreign codes, plain and behind the y prefix
   logic [15:0] prog [15] = '{16'h001B, 16'h003A, 16'h183A, 16'h0089, 16'h0099, 16'h00B9, 16'h00A9,
      16'h00C9, 16'h00D9, 16'h00F9, 16'h00E9, 16'h18A9, 16'h18E9, 16'h0001, 16'h1801};
   aie_note_t notes[$];
   aie_note_t nt;
   int err_count = 0, total_checks = 0, cyc = 0, sd;
   aie_add_exec i_aie_add_exec (.core_clk(core_clk), .arst_n(arst_n), .run(run), .load_en(load_en),
      .load_sel(load_sel), .load_data(load_data), .bus_addr(bus_addr), .bus_rw(bus_rw), .bus_cycle(bus_cycle),
      .bus_rdata(bus_rdata), .accumulator_a(accumulator_a), .accumulator_b(accumulator_b), .index_x(index_x),
      .index_y(index_y), .condition_flags(condition_flags), .pc(pc), .rel_target(rel_target),
      .instr_done(instr_done), .bad_opcode(bad_opcode));
   aie_mem_model i_aie_mem_model (.core_clk(core_clk), .bus_addr(bus_addr), .bus_cycle(bus_cycle),
      .bus_rdata(bus_rdata));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task load(input logic [2:0] s, input logic [15:0] d);
      @(posedge core_clk);
      load_en <= 1'b1;
      load_sel <= s;
      load_data <= d;
      @(posedge core_clk);
      load_en <= 1'b0;
   endtask
   task put(input logic [7:0] v);
      i_aie_mem_model.mem[wp] = v;
      wp = wp + 16'h0001;
   endtask
   // sum with carry in; returns new flags over the 8-bit result
   function automatic logic [15:0] adc8(input logic [7:0] a, input logic [7:0] m, input logic c);
      logic [8:0] r;
      logic h;
      r = a + m + c;
      h = ({1'b0, a[3:0]} + m[3:0] + c) > 5'h0F;
      adc8 = {mf[7:6], h, mf[4], r[7], r[7:0] == 8'h00, (a[7] == m[7]) && (r[7] != a[7]), r[8], r[7:0]};
   endfunction
   // places one instruction in memory and notes what it must leave behind
   task automatic issue(input logic [15:0] code);
      logic [7:0] pre, op, p, q, m;
      logic [15:0] ea;
      logic bad;
      {pre, op} = code;
      bad = !(op == 8'h1B && pre == 8'h00) && op != 8'h3A
         && !(op[7] && op[3:0] == 4'h9 && (pre == 8'h00 || op[5:4] == 2'h2));
      p = $urandom;
      q = $urandom;
      if (pre != 8'h00)
         put(pre);
      put(op);
      if (op == 8'h1B && !bad)
         {mf, ma} = adc8(ma, mb, 1'b0);
      else if (op == 8'h3A && pre == 8'h00)
         mx = mx + {8'h00, mb};
      else if (op == 8'h3A)
         my = my + {8'h00, mb};
      else if (!bad)
      begin
         if (op[4])
            p[7] = 1'b1;
         mrel = wp + 16'h0001 + {{8{p[7]}}, p};
         put(p);
         if (op[5:4] == 2'h3)
            put(q);
         ea = (pre != 8'h00 ? my : mx) + {8'h00, p};
         if (op[5:4] == 2'h1)
            ea = {8'h00, p};
         if (op[5:4] == 2'h3)
            ea = {p, q};
         m = op[5:4] == 2'h0 ? p : i_aie_mem_model.mem[ea];
         if (op[6])
            {mf, mb} = adc8(mb, m, mf[0]);
         else
            {mf, ma} = adc8(ma, m, mf[0]);
      end
      notes.push_back('{ma, mb, mf, mx, my, mrel, wp, op[7] && pre == 8'h00 && !bad, bad});
   endtask
   // ----------------------------------------
   // clock, stimulus, result watcher
   // ----------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         end_of_test;
      end
   end
   always @(negedge core_clk)
      if (instr_done === 1'b1 && notes.size() > 0)
      begin
         nt = notes.pop_front();
         chk("acc_a", nt.a, accumulator_a);
         chk("acc_b", nt.b, accumulator_b);
         chk("idx_x", nt.x, index_x);
         chk("idx_y", nt.y, index_y);
         chk("flags", nt.f, condition_flags);
         chk("bad_op", {15'h0000, nt.bad}, bad_opcode);
         chk("pc", nt.pc, pc);
         if (nt.relc)
            chk("rel", nt.rel, rel_target);
      end
   initial
   begin
      arst_n = 1'b0;
      run = 1'b0;
      load_en = 1'b0;
      load_sel = 3'h0;
      load_data = 16'h0000;
      sd = $urandom(57514);
      for (int i = 0; i < 65536; i++)
         i_aie_mem_model.mem[i] = $urandom;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      @(negedge core_clk);
      chk("rst_ab", 16'h0000, {accumulator_a, accumulator_b});
      chk("rst_xy", 16'h0000, index_x | index_y);
      chk("rst_flags", 16'h00D0, condition_flags);
      chk("rst_pc", 16'h0000, pc);
      $display("test reset done");
      ma = $urandom;
      mb = $urandom;
      mf = 8'hD0 | ($urandom & 8'h01);
      // index bases kept clear of the program and page zero
      mx = 16'h0100 + ($urandom & 16'h7FFF);
      my = 16'h0100 + ($urandom & 16'h7FFF);
      load(3'h0, {8'h00, ma});
      load(3'h1, {8'h00, mb});
      load(3'h2, mx);
      load(3'h3, my);
      load(3'h4, {8'h00, mf});
      load(3'h5, 16'h0000);
      @(negedge core_clk);
      chk("load_x", mx, index_x);
      chk("load_flags", mf, condition_flags);
      $display("test load done");
      wp = 16'h0000;
      for (int r = 0; r < 2; r++)
         for (int k = 0; k < 15; k++)
            issue(prog[k]);
      @(posedge core_clk);
      run <= 1'b1;
      while (notes.size() > 0)
         @(posedge core_clk);
      run <= 1'b0;
      $display("test program done");
      end_of_test;
   end
endmodule

// ### tb/aie_add_exec_props.sv
// concurrent checks on the add execution unit ports
`timescale 1ns/1ps
module aie_add_exec_props
(
   input wire core_clk,
   input wire arst_n,
   input wire load_en,
   input wire [15:0] bus_addr,
   input wire bus_rw,
   input wire bus_cycle,
   input wire [7:0] bus_rdata,
   input wire [7:0] accumulator_a,
   input wire [7:0] accumulator_b,
   input wire [15:0] index_x,
   input wire [15:0] index_y,
   input wire [7:0] condition_flags,
   input wire instr_done
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // opcode fetch right after a finished instruction
   // ----------------------------------------
   sequence op_fetch(logic [7:0] code);
      instr_done && bus_cycle && bus_rdata == code;
   endsequence
   sequence next_byte;
      bus_addr == $past(bus_addr) + 16'h0001;
   endsequence
   rw_high_a: assert property (bus_rw == 1'b1)
      else $error("bus write seen");
   flag_fixed_a: assert property (!load_en |=> $stable({condition_flags[7:6], condition_flags[4]}))
      else $error("fixed flag bits moved");
   // add-with-carry into b may move it, but only as that instruction completes
   b_kept_a: assert property (!load_en |=> $stable(accumulator_b) || instr_done)
      else $error("accumulator b changed");
   aba_sum_a: assert property (op_fetch(8'h1B) |-> ##1 next_byte ##1 instr_done
      && accumulator_a == $past(accumulator_a, 2) + $past(accumulator_b, 2)
      && accumulator_b == $past(accumulator_b, 2)) else $error("b to a sum wrong");
   aba_carry_a: assert property (op_fetch(8'h1B) |-> ##2 condition_flags[0] ==
      (({1'b0, $past(accumulator_a, 2)} + {1'b0, $past(accumulator_b, 2)}) > 9'h0FF)) else $error("carry wrong");
   abx_walk_a: assert property (op_fetch(8'h3A) |-> ##1 next_byte ##1 bus_addr == 16'hFFFF ##1
      instr_done && index_x == $past(index_x, 3) + {8'h00, $past(accumulator_b, 3)}
      && accumulator_b == $past(accumulator_b, 3)) else $error("b to x wrong");
   aby_walk_a: assert property (op_fetch(8'h18) ##1 bus_rdata == 8'h3A |-> ##1 next_byte
      ##1 bus_addr == 16'hFFFF ##1 instr_done
      && index_y == $past(index_y, 4) + {8'h00, $past(accumulator_b, 4)}) else $error("b to y wrong");
   dir_page0_a: assert property (op_fetch(8'h99) |=> bus_cycle ##1
      bus_addr == {8'h00, $past(bus_rdata)}) else $error("direct address wrong");
   full_addr_a: assert property (op_fetch(8'hB9) |-> ##1 next_byte ##1 next_byte ##1
      bus_addr == {$past(bus_rdata, 2), $past(bus_rdata)}) else $error("full address wrong");
   xoff_addr_a: assert property (op_fetch(8'hA9) |-> ##2 bus_addr == 16'hFFFF ##1
      bus_addr == index_x + {8'h00, $past(bus_rdata, 2)}) else $error("x offset address wrong");
   lit_len_a: assert property (op_fetch(8'h89) |-> ##1 !instr_done ##1 instr_done)
      else $error("literal length wrong");
endmodule
bind aie_add_exec aie_add_exec_props i_aie_add_exec_props
(
   .core_clk(core_clk),
   .arst_n(arst_n),
   .load_en(load_en),
   .bus_addr(bus_addr),
   .bus_rw(bus_rw),
   .bus_cycle(bus_cycle),
   .bus_rdata(bus_rdata),
   .accumulator_a(accumulator_a),
   .accumulator_b(accumulator_b),
   .index_x(index_x),
   .index_y(index_y),
   .condition_flags(condition_flags),
   .instr_done(instr_done)
);

// ### tb/aie_mem_model.sv
// behavioural memory on the core read bus
`timescale 1ns/1ps
module aie_mem_model
(
   input wire core_clk,
   input wire [15:0] bus_addr,
   input wire bus_cycle,
   output logic [7:0] bus_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h00;
   // no read this cycle: show the inverse so stale data cannot pass
   always @* bus_rdata = bus_cycle ? mem[bus_addr] : ~last;
   always @(posedge core_clk)
      if (bus_cycle)
         last <= mem[bus_addr];
endmodule
